// ### verilog/ladder_ref_pkg.sv
// Package for the resistor-ladder reference control block.
// Assumes a 32-bit classic Wishbone register bus and one system clock.
package ladder_ref_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET  = 8'h00;
  localparam logic [7:0] LEVEL_OFFSET = 8'h04;

  // Control register field positions
  localparam int ENABLE_BIT = 7;
  localparam int LPS_BIT    = 6;
  localparam int PINOE_BIT  = 5;
  localparam int PSS_LSB    = 2;
  localparam int PSS_W      = 2;

  // Level register field layout
  localparam int CODE_W = 5;
  localparam int LEVELS = 2 ** CODE_W;

  // Implemented bit masks and reset values
  localparam logic [7:0] CTRL_MASK   = 8'hec;
  localparam logic [7:0] LEVEL_MASK  = 8'h1f;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;

  // Clamp codes
  localparam logic [CODE_W-1:0] CODE_ALL_ONES  = 5'h1f;
  localparam logic [CODE_W-1:0] CODE_ALL_ZEROS = 5'h00;

  // Positive source select encodings
  typedef enum logic [PSS_W-1:0] {
    SRC_SUPPLY   = 2'h0,
    SRC_EXT_PIN  = 2'h1,
    SRC_FIXEDREF = 2'h2,
    SRC_RESERVED = 2'h3
  } pos_source_t;

  // One-hot positive source switch positions
  localparam int SW_SUPPLY   = 0;
  localparam int SW_EXT_PIN  = 1;
  localparam int SW_FIXEDREF = 2;

  // Analog-side control bundle
  typedef struct packed {
    logic              ladderActive;   // Ladder powered and tapping
    logic [CODE_W-1:0] tapSelect;      // Tap index, output = neg + span*tap/32
    logic [2:0]        posSourceOn;    // One-hot positive source switch
    logic              negSourceOn;    // Ground end of the ladder connected
    logic              clampToPos;     // Output tied straight to positive source
    logic              clampToNeg;     // Output tied straight to ground
    logic              toComparator;   // Ladder feeds comparator positive input
    logic              toConverter;    // Ladder feeds converter channel
    logic              pinRoute;       // Ladder voltage on the shared pin
    logic              pinDigOutOff;   // Pin digital output driver forced off
    logic              pinDigInOff;    // Pin input threshold detector forced off
  } ladder_ctl_t;

endpackage : ladder_ref_pkg

// ### verilog/ladder_reference_control.sv
// Control logic for a 32-level resistor-ladder voltage reference.
// Assumes a classic Wishbone master on clk and an asynchronous pin input.
module ladder_reference_control
  import ladder_ref_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        padIn,
  output logic             padReadValue,
  output ladder_ctl_t      ladderCtl
);

  logic [7:0]  ctrlReg;
  logic [7:0]  levelReg;
  logic [7:0]  next_ctrl;
  logic [7:0]  next_level;
  logic        busWrite;
  logic        padMeta;
  logic        padSync;
  ladder_ctl_t next_ctl;

  // Decode the two register settings into analog switch controls
  function automatic ladder_ctl_t decode_ladder(input logic [7:0] ctrl, input logic [7:0] level);
    ladder_ctl_t c;
    logic        en;
    logic        lps;
    logic [CODE_W-1:0] code;
    c    = '0;
    en   = ctrl[ENABLE_BIT];
    lps  = ctrl[LPS_BIT];
    code = level[CODE_W-1:0];
    c.ladderActive = en;
    c.tapSelect    = en ? code : CODE_ALL_ZEROS;
    c.clampToPos   = !en && lps && (code == CODE_ALL_ONES);
    c.clampToNeg   = !en && !lps && (code == CODE_ALL_ZEROS);
    c.negSourceOn  = en || !lps;
    if (en || lps) begin
      case (pos_source_t'(ctrl[PSS_LSB +: PSS_W]))
        SRC_SUPPLY:   c.posSourceOn[SW_SUPPLY]   = 1'b1;
        SRC_EXT_PIN:  c.posSourceOn[SW_EXT_PIN]  = 1'b1;
        SRC_FIXEDREF: c.posSourceOn[SW_FIXEDREF] = 1'b1;
        default:      c.posSourceOn              = 3'h0;
      endcase
    end
    c.toComparator = 1'b1;
    c.toConverter  = 1'b1;
    c.pinRoute     = ctrl[PINOE_BIT];
    c.pinDigOutOff = ctrl[PINOE_BIT];
    c.pinDigInOff  = ctrl[PINOE_BIT];
    return c;
  endfunction : decode_ladder

  // Write lands on the edge where the master samples ack high
  assign busWrite = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  always_comb begin
    next_ctrl  = ctrlReg;
    next_level = levelReg;
    if (busWrite && adr_i == CTRL_OFFSET) begin
      next_ctrl = dat_i[7:0] & CTRL_MASK;
    end
    if (busWrite && adr_i == LEVEL_OFFSET) begin
      next_level = dat_i[7:0] & LEVEL_MASK;
    end
    next_ctl = decode_ladder(next_ctrl, next_level);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlReg  <= CTRL_RESET;
      levelReg <= LEVEL_RESET;
    end else begin
      ctrlReg  <= next_ctrl;
      levelReg <= next_level;
    end
  end

  // analog controls follow the written value on the same edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ladderCtl <= '0;
    end else begin
      ladderCtl <= next_ctl;
    end
  end

  // Bus answer: ack one cycle after request, dropped after one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // read data with unimplemented bits zero; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dat_o <= 32'h0;
    end else if (cyc_i && stb_i && !ack_o) begin
      case (adr_i)
        CTRL_OFFSET:  dat_o <= {24'h0, ctrlReg & CTRL_MASK};
        LEVEL_OFFSET: dat_o <= {24'h0, levelReg & LEVEL_MASK};
        default:      dat_o <= 32'h0;
      endcase
    end
  end

  // Pad level synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      padMeta <= 1'b0;
      padSync <= 1'b0;
    end else begin
      padMeta <= padIn;
      padSync <= padMeta;
    end
  end

  // digital read forced low while pin carries the ladder
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      padReadValue <= 1'b0;
    end else begin
      padReadValue <= padSync && !next_ctrl[PINOE_BIT];
    end
  end

  // Checks
  // Decoded controls first stand one edge after reset release; checks that
  // expect them skip the edge whose previous sample was still in reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Control write lands on the acknowledged edge
  AST_WRITE_CTRL_TAKES_EFFECT: assert property (
    busWrite && adr_i == CTRL_OFFSET |=> ctrlReg == ($past(dat_i[7:0]) & CTRL_MASK))
    else $error("control write did not land");

  // Level write lands on the acknowledged edge
  AST_WRITE_LEVEL_TAKES_EFFECT: assert property (
    busWrite && adr_i == LEVEL_OFFSET |=> levelReg == ($past(dat_i[7:0]) & LEVEL_MASK))
    else $error("level write did not land");

  // Control register holds without an accepted write
  AST_CTRL_HOLDS: assert property (
    !(busWrite && adr_i == CTRL_OFFSET) |=> $stable(ctrlReg))
    else $error("control register changed without a write");

  // Level register holds without an accepted write
  AST_LEVEL_HOLDS: assert property (
    !(busWrite && adr_i == LEVEL_OFFSET) |=> $stable(levelReg))
    else $error("level register changed without a write");

  // New level code reaches the tap while enabled
  AST_LEVEL_TO_TAP: assert property (
    busWrite && adr_i == LEVEL_OFFSET && ctrlReg[ENABLE_BIT] && !(adr_i == CTRL_OFFSET)
    |=> ladderCtl.tapSelect == $past(dat_i[CODE_W-1:0]))
    else $error("tap did not follow new level code");

  // Tap tracks the stored code while enabled
  AST_TAP_FOLLOWS_CODE: assert property (
    ctrlReg[ENABLE_BIT] |-> ladderCtl.tapSelect == levelReg[CODE_W-1:0])
    else $error("tap differs from stored level code");

  // Enabled ladder keeps its ground end and no clamp
  AST_ENABLED_NO_CLAMP: assert property (
    ctrlReg[ENABLE_BIT] |-> ladderCtl.ladderActive && ladderCtl.negSourceOn
      && !ladderCtl.clampToPos && !ladderCtl.clampToNeg)
    else $error("enabled ladder clamped or cut");

  // Disabled ladder is idle with a zero tap
  AST_INACTIVE_WHEN_DISABLED: assert property (
    !ctrlReg[ENABLE_BIT] |-> !ladderCtl.ladderActive && ladderCtl.tapSelect == CODE_ALL_ZEROS)
    else $error("ladder active while disabled");

  // Positive clamp at least power
  AST_CLAMP_POS: assert property (
    !ctrlReg[ENABLE_BIT] && ctrlReg[LPS_BIT] && levelReg[CODE_W-1:0] == CODE_ALL_ONES
    |-> ladderCtl.clampToPos && !ladderCtl.clampToNeg && !ladderCtl.negSourceOn)
    else $error("positive clamp missing");

  // Ground clamp at least power
  AST_CLAMP_NEG: assert property (
    !$past(rst) && !ctrlReg[ENABLE_BIT] && !ctrlReg[LPS_BIT] && levelReg[CODE_W-1:0] == CODE_ALL_ZEROS
    |-> ladderCtl.clampToNeg && ladderCtl.posSourceOn == 3'h0)
    else $error("negative clamp missing");

  // Source switch follows the select field while enabled
  AST_SOURCE_ONEHOT: assert property (
    ctrlReg[ENABLE_BIT] |-> (ctrlReg[PSS_LSB +: PSS_W] == SRC_RESERVED) ?
      ladderCtl.posSourceOn == 3'h0 : ladderCtl.posSourceOn == (3'h1 << ctrlReg[PSS_LSB +: PSS_W]))
    else $error("positive source switch wrong");

  // Never two positive sources at once
  AST_SOURCE_AT_MOST_ONE: assert property (
    $onehot0(ladderCtl.posSourceOn))
    else $error("two positive sources connected");

  // Pin drive overrides digital buffers
  AST_PIN_OVERRIDE: assert property (
    ctrlReg[PINOE_BIT] |-> ladderCtl.pinRoute && ladderCtl.pinDigOutOff && ladderCtl.pinDigInOff)
    else $error("pin digital buffers not overridden");

  // Pin left to digital use while drive is off
  AST_PIN_FREE_WHEN_OFF: assert property (
    !ctrlReg[PINOE_BIT] |-> !ladderCtl.pinRoute && !ladderCtl.pinDigOutOff
      && !ladderCtl.pinDigInOff)
    else $error("pin held by ladder while drive disabled");

  // Routed pin reads low
  AST_PIN_READS_ZERO: assert property (
    ctrlReg[PINOE_BIT] |-> !padReadValue)
    else $error("pin read nonzero while routed");

  // Read word carries only the addressed register's bits
  AST_RESERVED_READ_ZERO: assert property (
    ack_o |-> dat_o[31:8] == 24'h0 && (dat_o[7:0] & ~((adr_i == CTRL_OFFSET) ? CTRL_MASK :
      (adr_i == LEVEL_OFFSET) ? LEVEL_MASK : 8'h00)) == 8'h00)
    else $error("unimplemented bits read nonzero");

  // Unimplemented bits never stored
  AST_UNUSED_BITS_ZERO: assert property (
    (ctrlReg & ~CTRL_MASK) == 8'h00 && (levelReg & ~LEVEL_MASK) == 8'h00)
    else $error("unimplemented register bit stored");

  // Control read returns the stored value
  AST_READ_CTRL_DATA: assert property (
    ack_o && !we_i && adr_i == CTRL_OFFSET |-> dat_o == {24'h0, ctrlReg})
    else $error("control read data wrong");

  // Level read returns the stored value
  AST_READ_LEVEL_DATA: assert property (
    ack_o && !we_i && adr_i == LEVEL_OFFSET |-> dat_o == {24'h0, levelReg})
    else $error("level read data wrong");

  // Acknowledge is a single pulse one cycle after the request
  AST_ACK_ONE_CYCLE: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack timing wrong");

  // Acknowledge only answers a request
  AST_ACK_NEEDS_REQUEST: assert property (
    ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("ack without request");

  // Side select zero cuts the positive end while disabled
  AST_LOW_POWER_SIDE: assert property (
    !$past(rst) && !ctrlReg[ENABLE_BIT] && !ctrlReg[LPS_BIT]
    |-> ladderCtl.negSourceOn && ladderCtl.posSourceOn == 3'h0)
    else $error("low-power side select not honoured");

  // Side select one cuts the ground end while disabled
  AST_POS_SIDE_KEPT: assert property (
    !ctrlReg[ENABLE_BIT] && ctrlReg[LPS_BIT] |-> !ladderCtl.negSourceOn)
    else $error("ground end left connected");

  // Ladder feeds both the comparator and the converter
  AST_OUTPUT_FANOUT: assert property (
    !$past(rst) |-> ladderCtl.toComparator && ladderCtl.toConverter)
    else $error("ladder destinations not routed");

  // Main scenarios
  COV_ENABLED_RAMP: cover property (ladderCtl.ladderActive && ladderCtl.tapSelect == 5'h10);
  COV_CLAMP_POS: cover property (ladderCtl.clampToPos);
  COV_CLAMP_NEG: cover property (ladderCtl.clampToNeg && ladderCtl.pinRoute);
  COV_RESERVED_SOURCE: cover property (ladderCtl.ladderActive && ladderCtl.posSourceOn == 3'h0);
  COV_PIN_ROUTED_READ: cover property (ladderCtl.pinRoute && padSync);

endmodule : ladder_reference_control

// ### dv/ladder_reference_control_tb.sv
// Self-checking bench for the ladder reference control block.
// Assumes a classic Wishbone slave that answers within a few cycles of a request.
module ladder_reference_control_tb import ladder_ref_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic        padIn = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dout;
  logic [31:0] rd;
  logic        ack;
  logic        padReadValue;
  ladder_ctl_t ctl;
  logic [7:0]  mCtrl = 8'h00;   // Expected control register
  logic [7:0]  mLvl  = 8'h00;   // Expected level register
  logic [7:0]  a;
  int          r;
  int          n_fail = 0;
  int          n_checks = 0;

  ladder_reference_control DUT (
    .clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dout), .ack_o(ack), .padIn(padIn), .padReadValue(padReadValue),
    .ladderCtl(ctl)
  );

  // Free-running 250 MHz clock
  always #2 clk = ~clk;

  // Expected analog controls for given register contents
  function automatic ladder_ctl_t expCtl(input logic [7:0] c, input logic [7:0] l);
    ladder_ctl_t e;
    logic        en;
    logic        lps;
    en = c[ENABLE_BIT];
    lps = c[LPS_BIT];
    e = '0;
    e.ladderActive = en;
    e.tapSelect = en ? l[CODE_W-1:0] : 5'h00;
    if ((en || lps) && c[3:2] != 2'h3) e.posSourceOn[c[3:2]] = 1'b1;
    e.negSourceOn = en || !lps;
    e.clampToPos = !en && lps && (l[4:0] == 5'h1f);
    e.clampToNeg = !en && !lps && (l[4:0] == 5'h00);
    e.toComparator = 1'b1;
    e.toConverter = 1'b1;
    e.pinRoute = c[PINOE_BIT];
    e.pinDigOutOff = c[PINOE_BIT];
    e.pinDigInOff = c[PINOE_BIT];
    return e;
  endfunction : expCtl

  // Expected read word for an address
  function automatic logic [31:0] expRd(input logic [7:0] ad);
    if (ad == CTRL_OFFSET) return {24'h0, mCtrl};
    if (ad == LEVEL_OFFSET) return {24'h0, mLvl};
    return 32'h0;
  endfunction : expRd

  task automatic give_verdict;
    if (n_fail == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic fail(input string m);
    $display("BAD %0t %s", $time, m);
    n_fail++;
  endtask : fail

  // One classic cycle, held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    int k;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; dat <= d; sel <= s;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      fail("no acknowledge");
      give_verdict();
    end
    rd = dout;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
    wb(1'b1, ad, d, s);
    if (s[0] && ad == CTRL_OFFSET) mCtrl = d[7:0] & CTRL_MASK;
    if (s[0] && ad == LEVEL_OFFSET) mLvl = d[7:0] & LEVEL_MASK;
  endtask : wr

  task automatic chk_ctl;
    n_checks++;
    if (ctl !== expCtl(mCtrl, mLvl)) fail("ladder controls differ");
  endtask : chk_ctl

  task automatic chk_rd(input logic [7:0] ad);
    wb(1'b0, ad, $urandom, 4'hf);
    n_checks++;
    if (rd !== expRd(ad)) fail("read data differs");
  endtask : chk_rd

  // Hold the pin level long enough to pass the synchroniser
  task automatic chk_pad(input logic v);
    padIn <= v;
    repeat (4) @(posedge clk);
    n_checks++;
    if (padReadValue !== (v & ~mCtrl[PINOE_BIT])) fail("pin read differs");
  endtask : chk_pad

  task automatic reset_dut;
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    mCtrl = CTRL_RESET;
    mLvl = LEVEL_RESET;
    // Decoded controls stand only after the first edge past release
    @(posedge clk);
    @(posedge clk);
  endtask : reset_dut

  // Main sequence: directed corners, then random traffic, then a mid-run reset
  initial begin
    void'($urandom(21));
    reset_dut();
    chk_ctl();
    chk_rd(CTRL_OFFSET);
    chk_rd(LEVEL_OFFSET);
    wr(LEVEL_OFFSET, 32'h0b, 4'h1);
    for (int p = 0; p < 4; p++)
      for (int m = 0; m < 4; m++) begin
        wr(CTRL_OFFSET, 32'((m << 6) | (p << 2) | 32'h13), 4'h1);
        chk_ctl();
      end
    wr(CTRL_OFFSET, 32'h80, 4'h1);
    for (int c = 0; c < LEVELS; c++) begin
      wr(LEVEL_OFFSET, 32'(c) | 32'he0, 4'h1);
      chk_ctl();
    end
    chk_rd(LEVEL_OFFSET);
    wr(CTRL_OFFSET, 32'h44, 4'h1);
    wr(LEVEL_OFFSET, 32'h1f, 4'h1);
    chk_ctl();
    wr(CTRL_OFFSET, 32'h00, 4'h1);
    wr(LEVEL_OFFSET, 32'h00, 4'h1);
    chk_ctl();
    chk_pad(1'b1);
    chk_pad(1'b0);
    wr(CTRL_OFFSET, 32'h20, 4'h1);
    chk_ctl();
    chk_pad(1'b1);
    wr(LEVEL_OFFSET, 32'h0a, 4'he);
    chk_rd(LEVEL_OFFSET);
    wr(8'h08, 32'hff, 4'hf);
    chk_rd(8'h08);
    chk_rd(CTRL_OFFSET);
    for (int i = 0; i < 80; i++) begin
      r = $urandom % 4;
      a = (r == 3) ? 8'($urandom) : 8'(r * 4);
      if ($urandom % 2) begin
        wr(a, $urandom, 4'($urandom));
        chk_ctl();
      end else
        chk_rd(a);
      if (i % 8 == 0) chk_pad(1'($urandom));
    end
    wr(CTRL_OFFSET, 32'hac, 4'h1);
    wr(LEVEL_OFFSET, 32'h15, 4'h1);
    reset_dut();
    chk_ctl();
    chk_rd(CTRL_OFFSET);
    chk_rd(LEVEL_OFFSET);
    give_verdict();
  end
endmodule : ladder_reference_control_tb
